//--- rtl/scsom_pkg.sv
package scsom_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_CLK_MODE_0 = 12'h006;
    localparam logic [11:0] IDX_CLK_CTRL_1 = 12'h007;
    localparam logic [11:0] IDX_OSC_DETECT = 12'h00c;
    localparam logic [11:0] IDX_PLL_CTRL = 12'h01c;
    localparam logic [11:0] IDX_PERIPH_CLK = 12'h040;
    localparam logic [11:0] IDX_PROC_MODE_2 = 12'h041;
    localparam logic [11:0] IDX_WRITE_UNLOCK = 12'h042;
    localparam logic [11:0] IDX_CAN_CLK = 12'h25f;
    localparam logic [11:0] ADDR_CLK_MODE_0 = IDX_CLK_MODE_0 << 2;
    localparam logic [11:0] ADDR_CLK_CTRL_1 = IDX_CLK_CTRL_1 << 2;
    localparam logic [11:0] ADDR_OSC_DETECT = IDX_OSC_DETECT << 2;
    localparam logic [11:0] ADDR_PLL_CTRL = IDX_PLL_CTRL << 2;
    localparam logic [11:0] ADDR_PERIPH_CLK = IDX_PERIPH_CLK << 2;
    localparam logic [11:0] ADDR_PROC_MODE_2 = IDX_PROC_MODE_2 << 2;
    localparam logic [11:0] ADDR_WRITE_UNLOCK = IDX_WRITE_UNLOCK << 2;
    localparam logic [11:0] ADDR_CAN_CLK = IDX_CAN_CLK << 2;

    // Reset values
    localparam logic [7:0] RST_CLK_MODE_0 = 8'h40;
    localparam logic [7:0] RST_CLK_CTRL_1 = 8'h20;
    localparam logic [7:0] RST_PLL_CTRL = 8'h12;

    // Field positions
    localparam int B_HALT = 0;
    localparam int B_PLL_SEL = 1;
    localparam int B_DRIVE = 5;
    localparam int B_DIV_LO = 6;
    localparam int B_DET_EN = 0;
    localparam int B_ONCHIP = 1;
    localparam int B_FLAG = 2;
    localparam int B_MONITOR = 3;
    localparam int B_ACTION = 7;
    localparam int B_MULT_LO = 0;
    localparam int B_PLL_RSV = 4;
    localparam int B_PLL_EN = 7;
    localparam int B_CAN_DIV_LO = 0;
    localparam int B_CAN_SLEEP = 3;
    localparam int B_TIMER_SEL = 0;
    localparam int B_SERIAL_SEL = 1;
    localparam int B_SERIAL4 = 5;
    localparam int B_REMAP = 6;
    localparam int B_ADC_DIRECT = 7;
    localparam int B_SFR_WAIT = 0;
    localparam int B_WDT_LOCK = 2;
    localparam int B_MAIN_OFF = 5;
    localparam int B_DIV8 = 6;
    localparam int B_SUB_SEL = 7;
    localparam int B_UNLOCK = 0;

    // CPU clock source codes
    localparam logic [1:0] SRC_MAIN = 2'h0;
    localparam logic [1:0] SRC_PLL = 2'h1;
    localparam logic [1:0] SRC_ONCHIP = 2'h2;
    localparam logic [1:0] SRC_SUB = 2'h3;

    // Miscellaneous encodings
    localparam logic [2:0] CAN_DIV_MAX = 3'h4;
    localparam logic [1:0] WAIT_PLL_SLOW = 2'h2;
    localparam logic [1:0] WAIT_PLL_FAST = 2'h1;
    localparam logic [5:0] KEY_VEC_NORMAL = 6'h0e;
    localparam logic [5:0] KEY_VEC_REMAP = 6'h0d;
    localparam logic [15:0] KEY_CTRL_NORMAL = 16'h004e;
    localparam logic [15:0] KEY_CTRL_REMAP = 16'h004d;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- rtl/scsom_clock_ctrl.sv
// Notes on behaviour
// - Halt bit stops clocks, parks oscillator pins
// - Watchdog source lock blocks halt writes
// - PLL select works only on main path
// - Two-bit divider: 1, 2, 4, 16
// - Stop entry off sub clock, or main off on sub clock, forces drive high
// - Onchip off, main off: div8, drive held
// - Detect reset keeps enable, onchip, action bits
// - Action bit: 0 reset, 1 interrupt
// - Stop on main clock with action bit set selects onchip oscillator
// - Stop on PLL leaves onchip select alone
// - Flag sets on stop and restart; rise interrupts
// - Flag cleared only by writing zero
// - No interrupt while flag already set
// - Monitor bit reads one while main oscillator stopped
// - Timer/ADC and serial undivided select bits
// - ADC direct bit forces undivided ADC clock
// - Remap moves key vector and control address
// - SFR waits 2 or 1, PLL running only
// - Watchdog lock sticky, starts onchip oscillator
// - PLL multiplier writable once, PLL off only
// - Divide-by-eight override wins over divider
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module scsom_clock_ctrl
    import scsom_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Asynchronous status from the analog side
    input wire logic main_osc_stopped,
    input wire logic stop_wake,
    // Clock selection
    output logic [1:0] cpu_clock_source,
    output logic [4:0] main_divide_ratio,
    output logic main_drive_strength,
    output logic onchip_osc_enable,
    output logic watchdog_source_onchip,
    output logic pll_enable,
    output logic [2:0] pll_multiplier,
    // Stop mode pin control
    output logic stop_mode,
    output logic main_xout_high,
    output logic main_feedback_open,
    output logic sub_osc_pins_hiz,
    // Oscillation monitor events
    output logic osc_detect_irq,
    output logic osc_stop_reset,
    // Peripheral clocks
    output logic timer_clock_undivided,
    output logic adc_clock_undivided,
    output logic serial_clock_full_rate,
    output logic serial4_pin_switch,
    output logic [4:0] can_divide_ratio,
    output logic can_cpu_interface_sleep,
    output logic [1:0] sfr_wait_states,
    output logic [5:0] key_input_vector,
    output logic [15:0] key_input_irq_control_addr
);
    import scsom_pkg::*;

    typedef struct packed {
        logic awready, wready, bvalid, arready, rvalid;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata;
        logic aw_have, w_have, wstrb0;
        logic [11:0] awaddr;
        logic [7:0] wdata;
        logic halt, pll_sel, drive, det_en, onchip, flag, action;
        logic [1:0] div;
        logic [2:0] mult;
        logic mult_written, pll_en, can_sleep;
        logic [2:0] can_div;
        logic timer_sel, serial_sel, serial4, remap, adc_direct;
        logic sfr_wait, wdt_lock, main_off, div8, sub_sel, unlock;
        logic osc_s1, osc_s2, osc_prev, wake_s1, wake_s2;
        logic irq, osc_reset, osc_en, xout_hi, adc_undiv;
        logic [1:0] cpu_src, waits;
        logic [4:0] div_ratio, can_ratio;
        logic [5:0] key_vec;
        logic [15:0] key_addr;
    } scsom_state_type;

    scsom_state_type st_reg;
    scsom_state_type st_next;
    logic stop_ev;
    logic restart_ev;
    logic det_ev;

    // Main clock ratio; override beats the two-bit field
    function automatic logic [4:0] scsom_main_ratio(input logic d8, input logic [1:0] dv);
        if (d8) begin
            return 5'h08;
        end else if (dv == 2'h0) begin
            return 5'h01;
        end else if (dv == 2'h1) begin
            return 5'h02;
        end else if (dv == 2'h2) begin
            return 5'h04;
        end
        return 5'h10;
    endfunction

    // CAN ratio is a power of two of the code
    function automatic logic [4:0] scsom_can_ratio(input logic [2:0] code);
        return 5'(5'h01 << code);
    endfunction

    // Any address the map answers
    function automatic logic scsom_mapped(input logic [11:0] a);
        return (a == ADDR_CLK_MODE_0) || (a == ADDR_CLK_CTRL_1) || (a == ADDR_OSC_DETECT)
            || (a == ADDR_PLL_CTRL) || (a == ADDR_PERIPH_CLK) || (a == ADDR_PROC_MODE_2)
            || (a == ADDR_WRITE_UNLOCK) || (a == ADDR_CAN_CLK);
    endfunction

    // Register read view; reserved bits read zero except PLL control bit 4, which reads one
    function automatic logic [31:0] scsom_read(input scsom_state_type s, input logic [11:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_CLK_MODE_0) begin
            v[B_MAIN_OFF] = s.main_off;
            v[B_DIV8] = s.div8;
            v[B_SUB_SEL] = s.sub_sel;
        end else if (a == ADDR_CLK_CTRL_1) begin
            v[B_HALT] = s.halt;
            v[B_PLL_SEL] = s.pll_sel;
            v[B_DRIVE] = s.drive;
            v[B_DIV_LO +: 2] = s.div;
        end else if (a == ADDR_OSC_DETECT) begin
            v[B_DET_EN] = s.det_en;
            v[B_ONCHIP] = s.onchip;
            v[B_FLAG] = s.flag;
            v[B_MONITOR] = s.osc_s2;
            v[B_ACTION] = s.action;
        end else if (a == ADDR_PLL_CTRL) begin
            v[B_MULT_LO +: 3] = s.mult;
            v[B_PLL_RSV] = 1'b1;
            v[B_PLL_EN] = s.pll_en;
        end else if (a == ADDR_PERIPH_CLK) begin
            v[B_TIMER_SEL] = s.timer_sel;
            v[B_SERIAL_SEL] = s.serial_sel;
            v[B_SERIAL4] = s.serial4;
            v[B_REMAP] = s.remap;
            v[B_ADC_DIRECT] = s.adc_direct;
        end else if (a == ADDR_PROC_MODE_2) begin
            v[B_SFR_WAIT] = s.sfr_wait;
            v[B_WDT_LOCK] = s.wdt_lock;
        end else if (a == ADDR_WRITE_UNLOCK) begin
            v[B_UNLOCK] = s.unlock;
        end else if (a == ADDR_CAN_CLK) begin
            v[B_CAN_DIV_LO +: 3] = s.can_div;
            v[B_CAN_SLEEP] = s.can_sleep;
        end
        return {24'h00_0000, v};
    endfunction

    // Control fields except detect enable, onchip and action to reset values; bus and sync state untouched
    function automatic scsom_state_type scsom_ctrl_reset(input scsom_state_type s);
        scsom_state_type r;
        r = s;
        r.halt = RST_CLK_CTRL_1[B_HALT];
        r.pll_sel = RST_CLK_CTRL_1[B_PLL_SEL];
        r.drive = RST_CLK_CTRL_1[B_DRIVE];
        r.div = RST_CLK_CTRL_1[B_DIV_LO +: 2];
        r.flag = 1'b0;
        r.mult = RST_PLL_CTRL[B_MULT_LO +: 3];
        r.mult_written = 1'b0;
        r.pll_en = RST_PLL_CTRL[B_PLL_EN];
        r.can_div = 3'h0;
        r.can_sleep = 1'b0;
        {r.timer_sel, r.serial_sel, r.serial4, r.remap, r.adc_direct} = 5'h00;
        {r.sfr_wait, r.wdt_lock, r.unlock} = 3'h0;
        r.main_off = RST_CLK_MODE_0[B_MAIN_OFF];
        r.div8 = RST_CLK_MODE_0[B_DIV8];
        r.sub_sel = RST_CLK_MODE_0[B_SUB_SEL];
        return r;
    endfunction

    // Oscillator edges seen after the synchroniser
    assign stop_ev = st_reg.osc_s2 && !st_reg.osc_prev;
    assign restart_ev = !st_reg.osc_s2 && st_reg.osc_prev;
    assign det_ev = st_reg.det_en && (stop_ev || restart_ev);

    // Next state: bus, register writes, detection, derived outputs
    always_comb begin
        logic [7:0] d;
        logic [11:0] a;
        logic wr_ok;
        d = st_reg.wdata;
        a = st_reg.awaddr;
        wr_ok = 1'b0;
        st_next = st_reg;
        st_next.irq = 1'b0;
        st_next.osc_reset = 1'b0;
        st_next.osc_s1 = main_osc_stopped;
        st_next.osc_s2 = st_reg.osc_s1;
        st_next.osc_prev = st_reg.osc_s2;
        st_next.wake_s1 = stop_wake;
        st_next.wake_s2 = st_reg.wake_s1;
        // Address and data accepted in either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_have = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_have = 1'b1;
            st_next.wdata = s_axi_wdata[7:0];
            st_next.wstrb0 = s_axi_wstrb[0];
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = scsom_mapped(a) ? RESP_OKAY : RESP_SLVERR;
            wr_ok = scsom_mapped(a) && st_reg.wstrb0
                && (st_reg.unlock || a == ADDR_WRITE_UNLOCK);
        end
        // Register write effects
        if (wr_ok) begin
            if (a == ADDR_WRITE_UNLOCK) begin
                st_next.unlock = d[B_UNLOCK];
            end else if (a == ADDR_CLK_CTRL_1) begin
                st_next.pll_sel = d[B_PLL_SEL];
                st_next.drive = d[B_DRIVE];
                st_next.div = d[B_DIV_LO +: 2];
                if (d[B_HALT] && !st_reg.wdt_lock) begin
                    st_next.halt = 1'b1;
                    if (!st_reg.sub_sel) begin
                        st_next.drive = 1'b1;
                        st_next.div8 = 1'b1;
                    end
                end
            end else if (a == ADDR_OSC_DETECT) begin
                st_next.det_en = d[B_DET_EN];
                st_next.onchip = d[B_ONCHIP];
                st_next.action = d[B_ACTION];
                if (!d[B_FLAG]) begin
                    st_next.flag = 1'b0;
                end
            end else if (a == ADDR_PLL_CTRL) begin
                if (!st_reg.pll_en && !st_reg.mult_written) begin
                    st_next.mult = d[B_MULT_LO +: 3];
                    st_next.mult_written = 1'b1;
                end
                st_next.pll_en = d[B_PLL_EN];
            end else if (a == ADDR_CAN_CLK) begin
                if (d[B_CAN_DIV_LO +: 3] <= CAN_DIV_MAX) begin
                    st_next.can_div = d[B_CAN_DIV_LO +: 3];
                end
                st_next.can_sleep = d[B_CAN_SLEEP];
            end else if (a == ADDR_PERIPH_CLK) begin
                st_next.timer_sel = d[B_TIMER_SEL];
                st_next.serial_sel = d[B_SERIAL_SEL];
                st_next.serial4 = d[B_SERIAL4];
                st_next.remap = d[B_REMAP];
                st_next.adc_direct = d[B_ADC_DIRECT];
            end else if (a == ADDR_PROC_MODE_2) begin
                st_next.sfr_wait = d[B_SFR_WAIT];
                st_next.wdt_lock = st_reg.wdt_lock | d[B_WDT_LOCK];
            end else if (a == ADDR_CLK_MODE_0) begin
                if (d[B_MAIN_OFF] && !st_reg.main_off && st_reg.sub_sel) begin
                    st_next.drive = 1'b1;
                end
                st_next.main_off = d[B_MAIN_OFF];
                st_next.div8 = d[B_DIV8];
                st_next.sub_sel = d[B_SUB_SEL];
            end
        end
        // Wake from stop mode
        if (st_reg.halt && st_reg.wake_s2) begin
            st_next.halt = 1'b0;
        end
        // Detection after writes so that a set beats a clear
        if (det_ev) begin
            if (stop_ev && !st_reg.action) begin
                st_next = scsom_ctrl_reset(st_next);
                st_next.osc_reset = 1'b1;
            end else begin
                st_next.irq = st_reg.action && !st_reg.flag;
                if (stop_ev && st_reg.action && st_reg.cpu_src == SRC_MAIN) begin
                    st_next.onchip = 1'b1;
                end
            end
            st_next.flag = 1'b1;
        end
        // Held values while main is off and onchip is off
        if (!st_next.onchip && st_next.main_off) begin
            st_next.div8 = 1'b1;
            st_next.drive = 1'b1;
        end
        // Read channel; one read in flight
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = scsom_read(st_reg, s_axi_araddr);
            st_next.rresp = scsom_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        st_next.arready = !st_next.rvalid;
        st_next.awready = !st_next.aw_have && !st_next.bvalid;
        st_next.wready = !st_next.w_have && !st_next.bvalid;
        // Derived outputs registered with the state
        if (st_next.sub_sel) begin
            st_next.cpu_src = SRC_SUB;
        end else if (st_next.onchip) begin
            st_next.cpu_src = SRC_ONCHIP;
        end else begin
            st_next.cpu_src = st_next.pll_sel ? SRC_PLL : SRC_MAIN;
        end
        st_next.div_ratio = scsom_main_ratio(st_next.div8, st_next.div);
        st_next.can_ratio = scsom_can_ratio(st_next.can_div);
        if (!st_next.pll_en) begin
            st_next.waits = 2'h0;
        end else begin
            st_next.waits = st_next.sfr_wait ? WAIT_PLL_FAST : WAIT_PLL_SLOW;
        end
        st_next.key_vec = st_next.remap ? KEY_VEC_REMAP : KEY_VEC_NORMAL;
        st_next.key_addr = st_next.remap ? KEY_CTRL_REMAP : KEY_CTRL_NORMAL;
        st_next.osc_en = st_next.onchip | st_next.wdt_lock;
        st_next.xout_hi = st_next.halt | st_next.main_off;
        st_next.adc_undiv = st_next.timer_sel | st_next.adc_direct;
    end

    // State register; synchronous reset to constants only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.drive <= RST_CLK_CTRL_1[B_DRIVE];
            st_reg.mult <= RST_PLL_CTRL[B_MULT_LO +: 3];
            st_reg.div8 <= RST_CLK_MODE_0[B_DIV8];
            st_reg.div_ratio <= 5'h08;
            st_reg.can_ratio <= 5'h01;
            st_reg.key_vec <= KEY_VEC_NORMAL;
            st_reg.key_addr <= KEY_CTRL_NORMAL;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign cpu_clock_source = st_reg.cpu_src;
    assign main_divide_ratio = st_reg.div_ratio;
    assign main_drive_strength = st_reg.drive;
    assign onchip_osc_enable = st_reg.osc_en;
    assign watchdog_source_onchip = st_reg.wdt_lock;
    assign pll_enable = st_reg.pll_en;
    assign pll_multiplier = st_reg.mult;
    assign stop_mode = st_reg.halt;
    assign main_xout_high = st_reg.xout_hi;
    assign main_feedback_open = st_reg.halt;
    assign sub_osc_pins_hiz = st_reg.halt;
    assign osc_detect_irq = st_reg.irq;
    assign osc_stop_reset = st_reg.osc_reset;
    assign timer_clock_undivided = st_reg.timer_sel;
    assign adc_clock_undivided = st_reg.adc_undiv;
    assign serial_clock_full_rate = st_reg.serial_sel;
    assign serial4_pin_switch = st_reg.serial4;
    assign can_divide_ratio = st_reg.can_ratio;
    assign can_cpu_interface_sleep = st_reg.can_sleep;
    assign sfr_wait_states = st_reg.waits;
    assign key_input_vector = st_reg.key_vec;
    assign key_input_irq_control_addr = st_reg.key_addr;

    // Checks; one clock domain
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_pair;
        st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    endsequence
    sequence s_locked_halt_write;
        s_write_pair ##0 (st_reg.awaddr == ADDR_CLK_CTRL_1 && st_reg.wdata[B_HALT]
            && st_reg.wdt_lock && !st_reg.halt);
    endsequence
    property p_halt_lock;
        s_locked_halt_write |=> !stop_mode;
    endproperty
    a_halt_lock: assert property (p_halt_lock)
        else $error("halt taken while watchdog lock set");
    property p_src_pll;
        (!st_reg.sub_sel && !st_reg.onchip) |->
            cpu_clock_source == (st_reg.pll_sel ? SRC_PLL : SRC_MAIN);
    endproperty
    a_src_pll: assert property (p_src_pll)
        else $error("cpu source mismatch on main path");
    property p_div8;
        st_reg.div8 |-> main_divide_ratio == 5'h08;
    endproperty
    a_div8: assert property (p_div8)
        else $error("override did not give divide by eight");
    property p_held;
        (!st_reg.onchip && st_reg.main_off) |-> (st_reg.div8 && main_drive_strength);
    endproperty
    a_held: assert property (p_held)
        else $error("div8 or drive not held with main off");
    property p_auto_onchip;
        (det_ev && stop_ev && st_reg.action && cpu_clock_source == SRC_MAIN) |=> st_reg.onchip;
    endproperty
    a_auto_onchip: assert property (p_auto_onchip)
        else $error("onchip not selected on main stop");
    property p_irq_once;
        osc_detect_irq |-> (st_reg.flag && !$past(st_reg.flag));
    endproperty
    a_irq_once: assert property (p_irq_once)
        else $error("interrupt raised with flag already set");
    property p_lock_sticky;
        st_reg.wdt_lock |=> st_reg.wdt_lock [*3];
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("watchdog lock cleared");
    property p_mult_once;
        (st_reg.mult_written && !det_ev) |=> $stable(pll_multiplier);
    endproperty
    a_mult_once: assert property (p_mult_once)
        else $error("multiplier changed after first write");
    property p_wait_pll;
        !st_reg.pll_en |-> sfr_wait_states == 2'h0;
    endproperty
    a_wait_pll: assert property (p_wait_pll)
        else $error("sfr waits applied with pll off");
    property p_resp;
        s_write_pair |=> s_axi_bvalid;
    endproperty
    a_resp: assert property (p_resp)
        else $error("write response missing");

endmodule
`default_nettype wire

//--- test/scsom_clock_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module scsom_clock_ctrl_tb;
    import scsom_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot, pll_multiplier;
    logic [31:0] s_axi_wdata, s_axi_rdata, x;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, cpu_clock_source, sfr_wait_states;
    logic main_osc_stopped, stop_wake, main_drive_strength, onchip_osc_enable, pll_enable;
    logic watchdog_source_onchip, stop_mode, main_xout_high, main_feedback_open, sub_osc_pins_hiz;
    logic osc_detect_irq, osc_stop_reset, timer_clock_undivided, adc_clock_undivided;
    logic serial_clock_full_rate, serial4_pin_switch, can_cpu_interface_sleep;
    logic [4:0] main_divide_ratio, can_divide_ratio;
    logic [5:0] key_input_vector;
    logic [15:0] key_input_irq_control_addr;
    logic [33:0] q[$];
    int err_total, checked, n, k;
    scsom_clock_ctrl i_scsom_clock_ctrl (.*);
    // Free-running 10 MHz clock
    always #50 aclk = ~aclk;
    function automatic logic [31:0] xs();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task chk(input string s, input logic [33:0] v, input logic [33:0] e);
        checked++;
        if (v !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", s, e, v);
        end
    endtask
    task report_and_stop();
        if (err_total == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Read answers checked against the oldest note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready && q.size() > 0) chk("rd", {s_axi_rresp, s_axi_rdata}, q.pop_front());
    end
    task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {xs() & 32'hffff_ff00} | d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) begin err_total++; report_and_stop(); end
        chk("bresp", s_axi_bresp, r);
    endtask
    task rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        q.push_back({r, 24'h0, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) begin err_total++; report_and_stop(); end
    endtask
    // Count event pulses over a window past the sync delay
    task cnt(input bit sel, output int c);
        c = 0;
        repeat (12) begin @(posedge aclk); c += sel ? osc_stop_reset : osc_detect_irq; end
    endtask
    task rst();
        aresetn <= 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
    endtask
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 0;
        {main_osc_stopped, stop_wake} = 0;
        s_axi_wstrb = 4'hf;
        x = 32'd8;
        rst();
        chk("div", main_divide_ratio, 5'd8);
        rd(ADDR_CLK_CTRL_1, RST_CLK_CTRL_1, RESP_OKAY);
        wr(ADDR_CLK_CTRL_1, 8'hc0, RESP_OKAY);
        rd(ADDR_CLK_CTRL_1, RST_CLK_CTRL_1, RESP_OKAY);
        wr(12'hffc, 8'h01, RESP_SLVERR);
        rd(12'hffc, 8'h00, RESP_SLVERR);
        wr(ADDR_WRITE_UNLOCK, 8'h01, RESP_OKAY);
        wr(ADDR_CLK_MODE_0, 8'h00, RESP_OKAY);
        for (k = 0; k < 4; k++) begin
            wr(ADDR_CLK_CTRL_1, 8'h20 | (k << 6), RESP_OKAY);
            chk("div", main_divide_ratio, (k == 3) ? 5'd16 : 5'd1 << k);
        end
        wr(ADDR_CLK_MODE_0, 8'h40, RESP_OKAY);
        chk("div8", main_divide_ratio, 5'd8);
        for (k = 0; k < 8; k++) begin
            wr(ADDR_CAN_CLK, k | (k << 3), RESP_OKAY);
            chk("can", {can_divide_ratio, can_cpu_interface_sleep}, {(k > 4) ? 5'd16 : 5'd1 << k, k[0]});
        end
        wr(ADDR_PERIPH_CLK, 8'he3, RESP_OKAY);
        chk("per", {timer_clock_undivided, serial_clock_full_rate, adc_clock_undivided, serial4_pin_switch}, 4'hf);
        chk("key", {key_input_vector, key_input_irq_control_addr}, {6'd13, 16'h004d});
        wr(ADDR_PERIPH_CLK, 8'h80, RESP_OKAY);
        chk("adc", {timer_clock_undivided, adc_clock_undivided}, 2'h1);
        wr(ADDR_CLK_CTRL_1, 8'h20, RESP_OKAY);
        wr(ADDR_CLK_MODE_0, 8'h00, RESP_OKAY);
        wr(ADDR_PLL_CTRL, 8'h13, RESP_OKAY);
        wr(ADDR_PLL_CTRL, 8'h91, RESP_OKAY);
        chk("pll", {pll_enable, pll_multiplier, sfr_wait_states}, {1'b1, 3'd3, 2'd2});
        wr(ADDR_PROC_MODE_2, 8'h01, RESP_OKAY);
        chk("wait", sfr_wait_states, 2'd1);
        wr(ADDR_CLK_CTRL_1, 8'h22, RESP_OKAY);
        chk("src", cpu_clock_source, SRC_PLL);
        wr(ADDR_OSC_DETECT, 8'h81, RESP_OKAY);
        main_osc_stopped <= 1;
        cnt(0, k);
        chk("irq", k, 1);
        rd(ADDR_OSC_DETECT, 8'h8d, RESP_OKAY);
        wr(ADDR_OSC_DETECT, 8'h83, RESP_OKAY);
        main_osc_stopped <= 0;
        cnt(0, k);
        chk("irq", k, 1);
        wr(ADDR_CLK_CTRL_1, 8'h20, RESP_OKAY);
        wr(ADDR_OSC_DETECT, 8'h81, RESP_OKAY);
        wr(ADDR_PLL_CTRL, 8'h13, RESP_OKAY);
        chk("src", {cpu_clock_source, sfr_wait_states}, {SRC_MAIN, 2'd0});
        wr(ADDR_OSC_DETECT, 8'h81, RESP_OKAY);
        main_osc_stopped <= 1;
        cnt(0, k);
        chk("irq", k, 1);
        rd(ADDR_OSC_DETECT, 8'h8f, RESP_OKAY);
        chk("src", cpu_clock_source, SRC_ONCHIP);
        main_osc_stopped <= 0;
        cnt(0, k);
        chk("irq", k, 0);
        wr(ADDR_OSC_DETECT, 8'h87, RESP_OKAY);
        rd(ADDR_OSC_DETECT, 8'h87, RESP_OKAY);
        wr(ADDR_OSC_DETECT, 8'h80, RESP_OKAY);
        rd(ADDR_OSC_DETECT, 8'h80, RESP_OKAY);
        wr(ADDR_CLK_MODE_0, 8'h20, RESP_OKAY);
        wr(ADDR_PROC_MODE_2, 8'h04, RESP_OKAY);
        wr(ADDR_PROC_MODE_2, 8'h00, RESP_OKAY);
        chk("wdt", {watchdog_source_onchip, onchip_osc_enable}, 2'h3);
        wr(ADDR_CLK_CTRL_1, 8'h01, RESP_OKAY);
        chk("halt", stop_mode, 1'b0);
        chk("held", {main_divide_ratio, main_drive_strength, main_xout_high}, 7'h23);
        rst();
        wr(ADDR_WRITE_UNLOCK, 8'h01, RESP_OKAY);
        wr(ADDR_OSC_DETECT, 8'h03, RESP_OKAY);
        main_osc_stopped <= 1;
        cnt(1, k);
        chk("rst", k, 1);
        rd(ADDR_OSC_DETECT, 8'h0f, RESP_OKAY);
        main_osc_stopped <= 0;
        wr(ADDR_WRITE_UNLOCK, 8'h01, RESP_OKAY);
        wr(ADDR_OSC_DETECT, 8'h00, RESP_OKAY);
        wr(ADDR_CLK_CTRL_1, 8'h01, RESP_OKAY);
        chk("stop", {stop_mode, main_xout_high, main_feedback_open, sub_osc_pins_hiz}, 4'hf);
        chk("drv", main_drive_strength, 1'b1);
        stop_wake <= 1;
        repeat (6) @(posedge aclk);
        chk("wake", stop_mode, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
